/* bench/slsr_host_model.sv */
// Host model driving decoded register requests into the line state register group.
// Assumes callers enter its tasks at a falling edge of clk_sys.
`timescale 1ns/10ps
`default_nettype none

module slsr_host_model
    import slsr_pkg::*;
(
    input wire logic clk_sys, // System clock
    output slsr_req_t req, // Request to the register group
    input wire logic [DATA_W-1:0] rdata, // Read data
    input wire logic rvalid // Read data valid
);
    // ----------------------------------------
    // Bus cycles
    // ----------------------------------------
    initial req = '0;

    // Write; an idle cycle follows so no two requests share one time step
    task automatic wr(input logic [CHAN_W-1:0] ch, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] d);
        req = '{wr: 1'b1, rd: 1'b0, chan: ch, addr: a, wdata: d};
        @(negedge clk_sys);
        req = '0;
        @(negedge clk_sys);
    endtask

    // Read; the answer stands only one cycle, so it is taken at once
    task automatic rd(input logic [CHAN_W-1:0] ch, input logic [ADDR_W-1:0] a,
                      output logic [DATA_W-1:0] d, output logic v);
        req = '{wr: 1'b0, rd: 1'b1, chan: ch, addr: a, wdata: 8'h00};
        @(negedge clk_sys);
        req = '0;
        d = rdata;
        v = rvalid;
        @(negedge clk_sys);
    endtask
endmodule

`default_nettype wire

/* bench/testbench.sv */
// Self-checking bench for the line state register group.
// Assumes two channels and a host model on the request port.
`timescale 1ns/10ps
`default_nettype none

module testbench;
    import slsr_pkg::*;
    logic clk_sys = 1'b0;
    logic rstn;
    slsr_req_t req;
    logic [7:0] rdata;
    logic rvalid;
    slsr_detect_t [1:0] detect;
    logic [1:0] ring_burst, cmbal_event, codec_loopback_enable, irq;
    logic [1:0][5:0] palm_event;
    logic [1:0][2:0] linefeed_commanded_state, linefeed_actual_state;
    logic [7:0] m_en [2], m_lb [2], m_lf [2], d;
    logic c;
    integer seed;
    int fail_count, checks_done;

    // ----------------------------------------
    // Instances and clock
    // ----------------------------------------
    slsr_regs #(.N_CHAN(2)) i_slsr_regs (.clk_sys(clk_sys), .rstn(rstn), .req(req),
        .rdata(rdata), .rvalid(rvalid), .detect(detect), .ring_burst(ring_burst),
        .cmbal_event(cmbal_event), .palm_event(palm_event),
        .linefeed_commanded_state(linefeed_commanded_state),
        .linefeed_actual_state(linefeed_actual_state),
        .codec_loopback_enable(codec_loopback_enable), .irq(irq));
    slsr_host_model i_slsr_host_model (.clk_sys(clk_sys), .req(req), .rdata(rdata),
        .rvalid(rvalid));
    always #10 clk_sys = ~clk_sys;

    // Shadow follows command, except silent ringing gaps show forward on-hook
    function automatic logic [2:0] exp_act(input logic [2:0] cmd, input logic burst);
        return (cmd == LF_RINGING && !burst) ? LF_FWD_OHT : cmd;
    endfunction

    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Read through the host and compare data and valid
    task automatic rchk(input logic ch, input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] rd;
        logic v;
        i_slsr_host_model.rd(ch, a, rd, v);
        chk("rvalid", {7'h00, v}, 8'h01);
        chk("rdata", rd, exp);
        // Read answer stands for one cycle only
        chk("rvalid_end", {7'h00, rvalid}, 8'h00);
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Watchdog so a hang still reaches the verdict
    initial begin
        repeat (20000) @(posedge clk_sys);
        fail_count++;
        end_sim();
    end

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        rstn = 1'b0;
        detect = '0;
        ring_burst = '0;
        cmbal_event = '0;
        palm_event = '0;
        seed = 80;
        repeat (12) @(negedge clk_sys);
        rstn = 1'b1;
        @(negedge clk_sys);
        for (int k = 0; k < 2; k++) begin
            m_en[k] = 8'h00;
            m_lb[k] = 8'h00;
            m_lf[k] = 8'h00;
            rchk(k[0], OFF_LOOPBACK, LOOPBACK_RESET);
            rchk(k[0], OFF_LINEFEED, 8'h00);
        end
        chk("loop_out", {6'h00, codec_loopback_enable}, 8'h00);
        $display("test reset done");
        // Random writes with reserved bits set; the other channel must not move
        for (int i = 0; i < 45; i++) begin
            c = 1'($random(seed));
            d = 8'($random(seed));
            if (i % 3 == 0) begin
                i_slsr_host_model.wr(c, OFF_IRQ_ENABLE3, d);
                m_en[c] = d & 8'hBF;
            end else if (i % 3 == 1) begin
                i_slsr_host_model.wr(c, OFF_LOOPBACK, d);
                m_lb[c] = d & 8'h80;
            end else begin
                i_slsr_host_model.wr(c, OFF_LINEFEED, d);
                m_lf[c] = {5'h00, d[2:0]};
            end
            rchk(c, OFF_IRQ_ENABLE3, m_en[c]);
            rchk(!c, OFF_IRQ_ENABLE3, m_en[!c]);
            rchk(c, OFF_LOOPBACK, m_lb[c]);
            d = {1'b0, exp_act(m_lf[c][2:0], 1'b0), m_lf[c][3:0]};
            rchk(c, OFF_LINEFEED, d);
            d = {6'h00, m_lb[1][7], m_lb[0][7]};
            chk("loop_out", {6'h00, codec_loopback_enable}, d);
            detect = 12'($random(seed));
            rchk(c, OFF_DETECT, {2'b00, detect[c]});
        end
        // Read-only and unmapped places; flags drop as soon as conditions clear
        i_slsr_host_model.wr(1'b0, OFF_DETECT, 8'hFF);
        detect = '0;
        rchk(1'b0, OFF_DETECT, 8'h00);
        rchk(1'b0, 8'h3C, 8'h00);
        $display("test random registers done");
        // Mid-run reset must turn a set loopback off again
        i_slsr_host_model.wr(1'b0, OFF_LOOPBACK, 8'h80);
        i_slsr_host_model.wr(1'b1, OFF_LOOPBACK, 8'hFF);
        chk("loop_out", {6'h00, codec_loopback_enable}, 8'h03);
        rstn = 1'b0;
        repeat (2) @(negedge clk_sys);
        rstn = 1'b1;
        @(negedge clk_sys);
        chk("loop_out", {6'h00, codec_loopback_enable}, 8'h00);
        rchk(1'b1, OFF_LOOPBACK, LOOPBACK_RESET);
        $display("test mid-run reset done");
        // Every linefeed code, with and without a ringing burst
        for (int b = 0; b < 2; b++) begin
            for (int k = 0; k < 8; k++) begin
                ring_burst = {b[0], b[0]};
                i_slsr_host_model.wr(1'b1, OFF_LINEFEED, {5'h00, k[2:0]});
                d = {5'h00, exp_act(k[2:0], b[0])};
                rchk(1'b1, OFF_LINEFEED, {d[3:0], 1'b0, k[2:0]});
                chk("lf_cmd", {5'h00, linefeed_commanded_state[1]}, {5'h00, k[2:0]});
                chk("lf_act", {5'h00, linefeed_actual_state[1]}, d);
            end
        end
        ring_burst = '0;
        $display("test linefeed done");
        // Pending events latch, enables gate them, write one clears
        i_slsr_host_model.wr(1'b0, OFF_IRQ_ENABLE3, 8'h80);
        i_slsr_host_model.wr(1'b1, OFF_IRQ_ENABLE3, 8'h00);
        cmbal_event[0] = 1'b1;
        palm_event[1] = 6'h20;
        @(negedge clk_sys);
        cmbal_event[0] = 1'b0;
        palm_event[1] = 6'h00;
        @(negedge clk_sys);
        chk("irq", {6'h00, irq}, 8'h01);
        rchk(1'b0, OFF_IRQ_STATUS3, 8'h80);
        i_slsr_host_model.wr(1'b1, OFF_IRQ_ENABLE3, 8'h20);
        chk("irq", {6'h00, irq}, 8'h03);
        i_slsr_host_model.wr(1'b0, OFF_IRQ_ENABLE3, 8'h00);
        chk("irq", {6'h00, irq}, 8'h02);
        i_slsr_host_model.wr(1'b0, OFF_IRQ_STATUS3, 8'h80);
        rchk(1'b0, OFF_IRQ_STATUS3, 8'h00);
        // First power alarm on channel zero, then a clear that meets a new event
        i_slsr_host_model.wr(1'b0, OFF_IRQ_ENABLE3, 8'h01);
        palm_event[0] = 6'h01;
        @(negedge clk_sys);
        palm_event[0] = 6'h00;
        @(negedge clk_sys);
        chk("irq", {6'h00, irq}, 8'h03);
        fork
            i_slsr_host_model.wr(1'b1, OFF_IRQ_STATUS3, 8'hFF);
            begin
                cmbal_event[1] = 1'b1;
                @(negedge clk_sys);
                cmbal_event[1] = 1'b0;
            end
        join
        rchk(1'b1, OFF_IRQ_STATUS3, 8'h80);
        chk("irq", {6'h00, irq}, 8'h01);
        $display("test interrupt gating done");
        end_sim();
    end
endmodule

`default_nettype wire

/* inc/slsr_pkg.sv */
// Constants, encodings and carriers for the per-channel line state register group.
// Assumes a control-bus front end that hands over decoded one-cycle register requests.
package slsr_pkg;

    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int CHANNELS = 2;
    localparam int CHAN_W = 1;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int LF_W = 3;
    localparam int PALM_N = 6;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFF_LINEFEED = 8'h06;
    localparam logic [ADDR_W-1:0] OFF_DETECT = 8'h09;
    localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS3 = 8'h11;
    localparam logic [ADDR_W-1:0] OFF_IRQ_ENABLE3 = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_LOOPBACK = 8'h16;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int LF_CMD_LSB = 0;
    localparam int LF_ACT_LSB = 4;
    localparam int CMBAL_BIT = 7;
    localparam int PALM_LSB = 0;
    localparam int LOOPBACK_BIT = 7;
    localparam int DETECT_W = 6;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [DATA_W-1:0] LOOPBACK_RESET = 8'h00;
    localparam logic [DATA_W-1:0] IRQ_ENABLE3_RESET = 8'h00;
    localparam logic [LF_W-1:0] LF_RESET = 3'h0;
    localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;

    // Linefeed encoding shared by commanded and shadow fields
    typedef enum logic [LF_W-1:0] {
        LF_OPEN = 3'h0,
        LF_FWD_ACTIVE = 3'h1,
        LF_FWD_OHT = 3'h2,
        LF_TIP_OPEN = 3'h3,
        LF_RINGING = 3'h4,
        LF_REV_ACTIVE = 3'h5,
        LF_REV_OHT = 3'h6,
        LF_RING_OPEN = 3'h7
    } slsr_lf_state_t;

    // Live detector levels, ordered as they read in the detect register
    typedef struct packed {
        logic common_mode_high_flag;
        logic speedup_flag;
        logic open_voltage_tracking_flag;
        logic ground_key_flag;
        logic ring_trip_flag;
        logic loop_closure_flag;
    } slsr_detect_t;

    // One decoded control-bus request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [CHAN_W-1:0] chan;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } slsr_req_t;

    // Stored state of one line channel
    typedef struct packed {
        logic [LF_W-1:0] lf_cmd;
        logic [LF_W-1:0] lf_act;
        logic cmbal_en;
        logic [PALM_N-1:0] palm_en;
        logic loopback;
        logic cmbal_pend;
        logic [PALM_N-1:0] palm_pend;
    } slsr_chan_t;

    // Whole block state
    typedef struct packed {
        slsr_chan_t [CHANNELS-1:0] ch;
        logic [DATA_W-1:0] rdata;
        logic rvalid;
    } slsr_state_t;

endpackage

/* src/slsr_regs.sv */
// Per-channel line state register group: linefeed, detect flags, alarm enables, loopback.
// Assumes decoded register requests synchronous to clk_sys and detector inputs already clean.
`timescale 1ns/10ps
`default_nettype none

module slsr_regs
    import slsr_pkg::*;
#(
    parameter int N_CHAN = CHANNELS
) (
    input wire logic clk_sys, // System clock, 50 MHz
    input wire logic rstn, // Synchronous reset, active low
    input wire slsr_req_t req, // Decoded register request
    output logic [DATA_W-1:0] rdata, // Read data, one cycle after rd
    output logic rvalid, // Read data valid pulse
    input wire slsr_detect_t [N_CHAN-1:0] detect, // Live detector levels
    input wire logic [N_CHAN-1:0] ring_burst, // High during a ringing burst
    input wire logic [N_CHAN-1:0] cmbal_event, // Common-mode balance event pulse
    input wire logic [N_CHAN-1:0][PALM_N-1:0] palm_event, // Power alarm event pulses
    output logic [N_CHAN-1:0][LF_W-1:0] linefeed_commanded_state, // Commanded state
    output logic [N_CHAN-1:0][LF_W-1:0] linefeed_actual_state, // Real-time state
    output logic [N_CHAN-1:0] codec_loopback_enable, // Loopback mode on
    output logic [N_CHAN-1:0] irq // Masked interrupt request per channel
);

    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    // Channel field width and state struct are sized for the package count
    if (N_CHAN != CHANNELS) begin : g_bad_chan
        $error("slsr_regs: N_CHAN must equal CHANNELS");
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Actual linefeed state from the command and the cadence phase
    function automatic logic [LF_W-1:0] shadow_of(input logic [LF_W-1:0] cmd,
                                                   input logic burst);
        logic [LF_W-1:0] s;
        s = cmd;
        if (cmd == LF_RINGING && !burst) begin
            s = LF_FWD_OHT;
        end
        return s;
    endfunction

    // Read image of one channel; unmapped and reserved bits come back zero
    function automatic logic [DATA_W-1:0] read_byte(input slsr_chan_t c,
                                                    input slsr_detect_t det,
                                                    input logic [ADDR_W-1:0] addr);
        logic [DATA_W-1:0] b;
        b = ZERO_BYTE;
        case (addr)
            OFF_LINEFEED: begin
                b[LF_CMD_LSB +: LF_W] = c.lf_cmd;
                b[LF_ACT_LSB +: LF_W] = c.lf_act;
            end
            OFF_DETECT: begin
                b[DETECT_W-1:0] = det;
            end
            OFF_IRQ_STATUS3: begin
                b[CMBAL_BIT] = c.cmbal_pend;
                b[PALM_LSB +: PALM_N] = c.palm_pend;
            end
            OFF_IRQ_ENABLE3: begin
                b[CMBAL_BIT] = c.cmbal_en;
                b[PALM_LSB +: PALM_N] = c.palm_en;
            end
            OFF_LOOPBACK: begin
                b[LOOPBACK_BIT] = c.loopback;
            end
            default: begin
                b = ZERO_BYTE;
            end
        endcase
        return b;
    endfunction

    slsr_state_t q;
    slsr_state_t d;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    // Writes first, then event sets, so a set in the clear cycle wins
    always_comb begin
        d = q;
        d.rvalid = req.rd;
        d.rdata = ZERO_BYTE;
        for (int c = 0; c < CHANNELS; c++) begin
            if (req.chan == CHAN_W'(c)) begin
                if (req.wr) begin
                    case (req.addr)
                        OFF_LINEFEED: begin
                            d.ch[c].lf_cmd = req.wdata[LF_CMD_LSB +: LF_W];
                        end
                        OFF_IRQ_ENABLE3: begin
                            d.ch[c].cmbal_en = req.wdata[CMBAL_BIT];
                            d.ch[c].palm_en = req.wdata[PALM_LSB +: PALM_N];
                        end
                        OFF_LOOPBACK: begin
                            d.ch[c].loopback = req.wdata[LOOPBACK_BIT];
                        end
                        OFF_IRQ_STATUS3: begin
                            // Write one to clear a pending bit
                            d.ch[c].cmbal_pend = q.ch[c].cmbal_pend & ~req.wdata[CMBAL_BIT];
                            d.ch[c].palm_pend = q.ch[c].palm_pend &
                                                ~req.wdata[PALM_LSB +: PALM_N];
                        end
                        default: begin
                            d.ch[c] = d.ch[c];
                        end
                    endcase
                end
                if (req.rd) begin
                    d.rdata = read_byte(q.ch[c], detect[c], req.addr);
                end
            end
            d.ch[c].cmbal_pend = d.ch[c].cmbal_pend | cmbal_event[c];
            d.ch[c].palm_pend = d.ch[c].palm_pend | palm_event[c];
            // Shadow lags the command by one cycle; it is a status view, not a drive
            d.ch[c].lf_act = shadow_of(q.ch[c].lf_cmd, ring_burst[c]);
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            q.rdata <= ZERO_BYTE;
            q.rvalid <= 1'b0;
            for (int c = 0; c < CHANNELS; c++) begin
                q.ch[c].lf_cmd <= LF_RESET;
                q.ch[c].lf_act <= LF_RESET;
                q.ch[c].cmbal_en <= IRQ_ENABLE3_RESET[CMBAL_BIT];
                q.ch[c].palm_en <= IRQ_ENABLE3_RESET[PALM_LSB +: PALM_N];
                q.ch[c].loopback <= LOOPBACK_RESET[LOOPBACK_BIT];
                q.ch[c].cmbal_pend <= 1'b0;
                q.ch[c].palm_pend <= '0;
            end
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign rdata = q.rdata;
    assign rvalid = q.rvalid;

    for (genvar g = 0; g < CHANNELS; g++) begin : g_out
        assign linefeed_commanded_state[g] = q.ch[g].lf_cmd;
        assign linefeed_actual_state[g] = q.ch[g].lf_act;
        assign codec_loopback_enable[g] = q.ch[g].loopback;
        // Pending bits gated by their enables
        assign irq[g] = (q.ch[g].cmbal_pend & q.ch[g].cmbal_en) |
                        (|(q.ch[g].palm_pend & q.ch[g].palm_en));
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);

    for (genvar g = 0; g < CHANNELS; g++) begin : g_chk
        chk_cmbal_en_store: assert property (
            req.wr && req.chan == CHAN_W'(g) && req.addr == OFF_IRQ_ENABLE3 |=>
            q.ch[g].cmbal_en == $past(req.wdata[CMBAL_BIT]))
            else $error("cmbal enable not stored");
        chk_palm_irq_gate: assert property (
            q.ch[g].palm_en == '0 && !q.ch[g].cmbal_en |-> !irq[g])
            else $error("irq while every source is masked");
        chk_loopback_out: assert property (
            req.wr && req.chan == CHAN_W'(g) && req.addr == OFF_LOOPBACK |=>
            codec_loopback_enable[g] == $past(req.wdata[LOOPBACK_BIT]))
            else $error("loopback enable not applied");
        chk_loopback_reset: assert property (
            $rose(rstn) |-> !codec_loopback_enable[g])
            else $error("loopback not off after reset");
        chk_detect_live: assert property (
            req.rd && req.chan == CHAN_W'(g) && req.addr == OFF_DETECT |=>
            rvalid && rdata == {2'b00, $past(detect[g])})
            else $error("detect read not live");
        chk_linefeed_store: assert property (
            req.wr && req.chan == CHAN_W'(g) && req.addr == OFF_LINEFEED |=>
            linefeed_commanded_state[g] == $past(req.wdata[LF_CMD_LSB +: LF_W]))
            else $error("linefeed command not adopted");
        chk_shadow_follow: assert property (
            linefeed_commanded_state[g] != LF_RINGING |=>
            linefeed_actual_state[g] == $past(linefeed_commanded_state[g]))
            else $error("shadow does not follow command");
        chk_ring_cadence: assert property (
            linefeed_commanded_state[g] == LF_RINGING |=>
            linefeed_actual_state[g] == ($past(ring_burst[g]) ? LF_RINGING : LF_FWD_OHT))
            else $error("ringing shadow wrong");
        chk_cmbal_latch: assert property (
            cmbal_event[g] ##1 q.ch[g].cmbal_en |-> q.ch[g].cmbal_pend && irq[g])
            else $error("cmbal event lost");
        chk_reserved_zero: assert property (
            req.rd && req.chan == CHAN_W'(g) && req.addr == OFF_LINEFEED |=>
            rdata[7] == 1'b0 && rdata[3] == 1'b0)
            else $error("reserved linefeed bits not zero");
        chk_chan_isolate: assert property (
            req.wr && req.chan != CHAN_W'(g) && !cmbal_event[g] |=>
            $stable(q.ch[g].lf_cmd) && $stable(q.ch[g].loopback))
            else $error("write leaked into other channel");
    end

endmodule

`default_nettype wire
